// ==== logic/pdrv_consts.vh ====
// constants shared by the pre-driver control logic
`ifndef PDRV_CONSTS_VH
`define PDRV_CONSTS_VH
`define PDRV_CLK_MHZ 50
`define PDRV_RST_NS 77
`define PDRV_RST_CYC ((`PDRV_RST_NS * `PDRV_CLK_MHZ) / 1000)
`define PDRV_FRAME_BITS 16
`define PDRV_CNT_W 5
`define PDRV_OP_HI 15
`define PDRV_OP_LO 12
`define PDRV_OP_NOP 4'h0
`define PDRV_OP_MASK_LO 4'h1
`define PDRV_OP_MASK_HI 4'h2
`define PDRV_OP_DEADTIME 4'h3
`define PDRV_OP_CONFIG 4'h4
`define PDRV_OP_CLR_INT 4'h5
`define PDRV_FAULTS 16
`define PDRV_MASK_RST 8'h00
`define PDRV_DT_W 8
`define PDRV_DT_RST 8'h0A
`define PDRV_CFG_DT_OVR 0
`define PDRV_CFG_XC_OVR 1
`define PDRV_CFG_RST 2'h0
`define PDRV_FLT_OC 0
`endif

// ==== logic/pdrv_sync.v ====
// two-stage synchroniser for signals from outside the clock domain
`timescale 1ns/100ps
module pdrv_sync #(
  parameter W = 1,
  parameter [W-1:0] RV = {W{1'b0}}
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // asynchronous input and synchronised output
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= RV;
      sync_q <= RV;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;
endmodule

// ==== logic/pdrv_spi.v ====
// serial port engine: shifts one frame in and the status word out
`timescale 1ns/100ps
`include "pdrv_consts.vh"
module pdrv_spi #(
  parameter FW = `PDRV_FRAME_BITS
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  input wire i_clr,
  // synchronised serial pins
  input wire i_sclk,
  input wire i_sdi,
  input wire i_cs_n,
  // word returned to the host
  input wire [FW-1:0] i_tx_word,
  // serial output
  output reg o_sdo,
  output reg o_sdo_oe_n,
  // received frame
  output reg [FW-1:0] o_rx_word,
  output reg o_rx_valid
);
  reg sclk_q;
  reg cs_n_q;
  reg [FW-1:0] tx_q;
  reg [FW-1:0] rx_q;
  reg [`PDRV_CNT_W-1:0] cnt_q;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_fall;
  wire cs_rise;

  assign sclk_rise = ~sclk_q & i_sclk;
  assign sclk_fall = sclk_q & ~i_sclk;
  assign cs_fall = cs_n_q & ~i_cs_n;
  assign cs_rise = ~cs_n_q & i_cs_n;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      tx_q <= {FW{1'b0}};
      rx_q <= {FW{1'b0}};
      cnt_q <= {`PDRV_CNT_W{1'b0}};
      o_sdo <= 1'b0;
      o_sdo_oe_n <= 1'b1;
      o_rx_word <= {FW{1'b0}};
      o_rx_valid <= 1'b0;
    end else if (i_clr) begin
      // port refused: no frame is taken and the output floats
      sclk_q <= i_sclk;
      cs_n_q <= 1'b1;
      cnt_q <= {`PDRV_CNT_W{1'b0}};
      o_sdo <= 1'b0;
      o_sdo_oe_n <= 1'b1;
      o_rx_valid <= 1'b0;
    end else begin
      sclk_q <= i_sclk;
      cs_n_q <= i_cs_n;
      o_rx_valid <= 1'b0;
      if (cs_fall) begin
        tx_q <= i_tx_word;
        cnt_q <= {`PDRV_CNT_W{1'b0}};
        o_sdo <= 1'b0;
        o_sdo_oe_n <= 1'b0;
      end else if (cs_rise) begin
        o_sdo_oe_n <= 1'b1;
        if (cnt_q == FW[`PDRV_CNT_W-1:0]) begin
          o_rx_word <= rx_q;
          o_rx_valid <= 1'b1;
        end
      end else if (!i_cs_n) begin
        if (sclk_rise) begin
          o_sdo <= tx_q[FW-1];
          tx_q <= {tx_q[FW-2:0], 1'b0};
        end
        if (sclk_fall) begin
          rx_q <= {rx_q[FW-2:0], i_sdi};
          if (cnt_q != {`PDRV_CNT_W{1'b1}}) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      end
    end
  end
endmodule

// ==== logic/pdrv_top.v ====
// control logic of the three-phase gate pre-driver
`timescale 1ns/100ps
`include "pdrv_consts.vh"
module pdrv_top #(
  parameter NF = `PDRV_FAULTS,
  parameter DTW = `PDRV_DT_W
) (
  // clock and system reset
  input wire i_clk,
  input wire i_rst_n,
  // device reset pin and power-on comparator
  input wire i_reset_n,
  input wire i_vdd_ok,
  // enables
  input wire i_enable_first,
  input wire i_enable_second,
  // phase commands
  input wire i_a_high_cmd_n,
  input wire i_a_low_cmd,
  input wire i_b_high_cmd_n,
  input wire i_b_low_cmd,
  input wire i_c_high_cmd_n,
  input wire i_c_low_cmd,
  // serial port
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_sdi,
  output wire o_sdo,
  output wire o_sdo_oe_n,
  // analog comparator and fault sources
  input wire [2:0] i_phase_above_half,
  input wire i_overcurrent,
  input wire [NF-1:0] i_fault,
  // gate drive commands
  output wire o_a_high_gate,
  output wire o_a_low_gate,
  output wire o_b_high_gate,
  output wire o_b_low_gate,
  output wire o_c_high_gate,
  output wire o_c_low_gate,
  // driver and supply control
  output wire o_drv_oe_n,
  output wire o_gate_pulldown,
  output wire o_bias_en,
  output wire o_vdd_reg_en,
  // status outputs
  output wire o_int,
  output wire o_phase_a_half_flag,
  output wire o_phase_b_half_flag,
  output wire o_phase_c_half_flag,
  output wire o_overcurrent_flag
);
  // cycles from reset pin fall to logic clear must not pass this
  localparam RST_CYC = `PDRV_RST_CYC;

  wire [2:0] hi_n_s;
  wire [2:0] lo_s;
  wire [1:0] en_s;
  wire [1:0] sup_s;
  wire [2:0] spi_s;
  wire [3:0] ana_s;
  wire [NF-1:0] flt_s;
  wire en_ok;
  wire logic_clr;
  wire gate_clr_n;
  wire [`PDRV_FRAME_BITS-1:0] rx_word;
  wire rx_valid;
  wire [3:0] opcode;
  wire [NF-1:0] mask_all;
  wire [NF-1:0] flt_pend;

  reg [2:0] gate_hi_q;
  reg [2:0] gate_lo_q;
  reg [2:0] gate_hi_d;
  reg [2:0] gate_lo_d;
  reg [2:0] boot_ok_q;
  reg [DTW-1:0] dt_cnt_q [0:2];
  reg [DTW-1:0] dt_cnt_d [0:2];
  reg [7:0] mask_lo_q;
  reg [7:0] mask_hi_q;
  reg [DTW-1:0] dt_len_q;
  reg [1:0] cfg_q;
  reg [NF-1:0] flt_q;
  reg int_q;
  reg clr_int;
  reg drv_oe_n_q;
  reg pulldown_q;
  reg bias_q;
  reg vreg_q;
  reg [2:0] half_q;
  reg oc_q;
  reg [2:0] want_hi;
  reg [2:0] want_lo;
  integer p;
  integer k;

  // input synchronisers
  pdrv_sync #(.W(3), .RV(3'h7)) u_sync_hi (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_c_high_cmd_n, i_b_high_cmd_n, i_a_high_cmd_n}),
    .o_q(hi_n_s)
  );
  pdrv_sync #(.W(3), .RV(3'h0)) u_sync_lo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_c_low_cmd, i_b_low_cmd, i_a_low_cmd}),
    .o_q(lo_s)
  );
  pdrv_sync #(.W(2), .RV(2'h0)) u_sync_en (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_enable_second, i_enable_first}),
    .o_q(en_s)
  );
  pdrv_sync #(.W(2), .RV(2'h0)) u_sync_sup (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_vdd_ok, i_reset_n}),
    .o_q(sup_s)
  );
  pdrv_sync #(.W(3), .RV(3'h1)) u_sync_spi (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_sdi, i_sclk, i_cs_n}),
    .o_q(spi_s)
  );
  pdrv_sync #(.W(4), .RV(4'h0)) u_sync_ana (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_overcurrent, i_phase_above_half}),
    .o_q(ana_s)
  );
  pdrv_sync #(.W(NF), .RV({NF{1'b0}})) u_sync_flt (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_fault),
    .o_q(flt_s)
  );

  // logic clear: two sync stages plus one edge stays within RST_CYC
  assign logic_clr = ~sup_s[0] | ~sup_s[1];
  assign en_ok = en_s[0] & en_s[1];
  // raw pins clear the gate flops without waiting for the clock
  assign gate_clr_n = i_rst_n & i_reset_n & i_enable_first & i_enable_second;

  // serial engine
  pdrv_spi #(.FW(`PDRV_FRAME_BITS)) u_spi (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clr(logic_clr),
    .i_sclk(spi_s[1]),
    .i_sdi(spi_s[2]),
    .i_cs_n(spi_s[0]),
    .i_tx_word(flt_q),
    .o_sdo(o_sdo),
    .o_sdo_oe_n(o_sdo_oe_n),
    .o_rx_word(rx_word),
    .o_rx_valid(rx_valid)
  );

  assign opcode = rx_word[`PDRV_OP_HI:`PDRV_OP_LO];

  // command decode and configuration
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_lo_q <= `PDRV_MASK_RST;
      mask_hi_q <= `PDRV_MASK_RST;
      dt_len_q <= `PDRV_DT_RST;
      cfg_q <= `PDRV_CFG_RST;
    end else if (logic_clr) begin
      mask_lo_q <= `PDRV_MASK_RST;
      mask_hi_q <= `PDRV_MASK_RST;
      dt_len_q <= `PDRV_DT_RST;
      cfg_q <= `PDRV_CFG_RST;
    end else if (rx_valid) begin
      case (opcode)
        `PDRV_OP_MASK_LO: begin
          mask_lo_q <= rx_word[7:0];
        end
        `PDRV_OP_MASK_HI: begin
          mask_hi_q <= rx_word[7:0];
        end
        `PDRV_OP_DEADTIME: begin
          dt_len_q <= rx_word[DTW-1:0];
        end
        `PDRV_OP_CONFIG: begin
          cfg_q <= rx_word[1:0];
        end
        default: begin
          cfg_q <= cfg_q;
        end
      endcase
    end
  end

  always @* begin
    clr_int = rx_valid & (opcode == `PDRV_OP_CLR_INT);
  end

  // fault latch and interrupt; a new fault wins over a clear
  assign mask_all = {mask_hi_q, mask_lo_q};
  assign flt_pend = flt_q & ~mask_all;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flt_q <= {NF{1'b0}};
      int_q <= 1'b0;
    end else if (logic_clr) begin
      flt_q <= {NF{1'b0}};
      int_q <= 1'b0;
    end else begin
      if (clr_int) begin
        flt_q <= flt_s;
      end else begin
        flt_q <= flt_q | flt_s;
      end
      int_q <= (clr_int ? |(flt_s & ~mask_all) : |flt_pend);
    end
  end

  // dead time, cross-conduction and bootstrap ordering
  always @* begin
    for (p = 0; p < 3; p = p + 1) begin
      want_hi[p] = en_ok & boot_ok_q[p] & ~hi_n_s[p];
      want_lo[p] = en_ok & lo_s[p];
      if (want_hi[p] & want_lo[p] & ~cfg_q[`PDRV_CFG_XC_OVR]) begin
        want_hi[p] = 1'b0;
        want_lo[p] = 1'b0;
      end
      if (cfg_q[`PDRV_CFG_DT_OVR]) begin
        gate_hi_d[p] = want_hi[p];
        gate_lo_d[p] = want_lo[p];
      end else begin
        gate_hi_d[p] = want_hi[p] & (gate_hi_q[p] |
          (~gate_lo_q[p] & (dt_cnt_q[p] == {DTW{1'b0}})));
        gate_lo_d[p] = want_lo[p] & (gate_lo_q[p] |
          (~gate_hi_q[p] & (dt_cnt_q[p] == {DTW{1'b0}})));
      end
      if ((gate_hi_q[p] & ~gate_hi_d[p]) | (gate_lo_q[p] & ~gate_lo_d[p])) begin
        dt_cnt_d[p] = dt_len_q;
      end else if (dt_cnt_q[p] != {DTW{1'b0}}) begin
        dt_cnt_d[p] = dt_cnt_q[p] - 1'b1;
      end else begin
        dt_cnt_d[p] = dt_cnt_q[p];
      end
    end
  end

  // gate flops drop at once when an enable or reset pin falls
  always @(posedge i_clk or negedge gate_clr_n) begin
    if (!gate_clr_n) begin
      gate_hi_q <= 3'h0;
      gate_lo_q <= 3'h0;
    end else if (logic_clr) begin
      gate_hi_q <= 3'h0;
      gate_lo_q <= 3'h0;
    end else begin
      gate_hi_q <= gate_hi_d;
      gate_lo_q <= gate_lo_d;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boot_ok_q <= 3'h0;
      for (k = 0; k < 3; k = k + 1) begin
        dt_cnt_q[k] <= {DTW{1'b0}};
      end
    end else if (logic_clr) begin
      boot_ok_q <= 3'h0;
      for (k = 0; k < 3; k = k + 1) begin
        dt_cnt_q[k] <= {DTW{1'b0}};
      end
    end else begin
      // a disable forgets the charge; a low-side pulse restores it
      if (!en_ok) begin
        boot_ok_q <= 3'h0;
      end else begin
        boot_ok_q <= boot_ok_q | gate_lo_q;
      end
      for (k = 0; k < 3; k = k + 1) begin
        dt_cnt_q[k] <= dt_cnt_d[k];
      end
    end
  end

  // supply, bias and driver state; flags follow the comparators and read 0 during logic clear
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drv_oe_n_q <= 1'b1;
      pulldown_q <= 1'b1;
      bias_q <= 1'b0;
      vreg_q <= 1'b0;
      half_q <= 3'h0;
      oc_q <= 1'b0;
    end else begin
      drv_oe_n_q <= ~sup_s[1];
      pulldown_q <= ~sup_s[0];
      bias_q <= sup_s[0];
      vreg_q <= sup_s[0];
      half_q <= logic_clr ? 3'h0 : ana_s[2:0];
      oc_q <= logic_clr ? 1'b0 : ana_s[3];
    end
  end

  assign o_a_high_gate = gate_hi_q[0];
  assign o_b_high_gate = gate_hi_q[1];
  assign o_c_high_gate = gate_hi_q[2];
  assign o_a_low_gate = gate_lo_q[0];
  assign o_b_low_gate = gate_lo_q[1];
  assign o_c_low_gate = gate_lo_q[2];
  assign o_drv_oe_n = drv_oe_n_q;
  assign o_gate_pulldown = pulldown_q;
  assign o_bias_en = bias_q;
  assign o_vdd_reg_en = vreg_q;
  assign o_int = int_q;
  assign o_phase_a_half_flag = half_q[0];
  assign o_phase_b_half_flag = half_q[1];
  assign o_phase_c_half_flag = half_q[2];
  assign o_overcurrent_flag = oc_q;
endmodule

// ==== tb/pdrv_checker.sv ====
// concurrent checks on the pre-driver control ports
`timescale 1ns/100ps
module pdrv_checker (
  // clock and resets
  input wire i_clk,
  input wire i_rst_n,
  input wire i_reset_n,
  input wire i_vdd_ok,
  // inputs watched
  input wire i_enable_first,
  input wire i_enable_second,
  input wire i_cs_n,
  input wire [2:0] i_phase_above_half,
  input wire i_overcurrent,
  // outputs watched
  input wire o_a_high_gate,
  input wire o_b_high_gate,
  input wire o_c_high_gate,
  input wire o_a_low_gate,
  input wire o_b_low_gate,
  input wire o_c_low_gate,
  input wire o_sdo_oe_n,
  input wire o_drv_oe_n,
  input wire o_gate_pulldown,
  input wire o_bias_en,
  input wire o_vdd_reg_en,
  input wire o_int,
  input wire o_phase_a_half_flag,
  input wire o_phase_b_half_flag,
  input wire o_phase_c_half_flag,
  input wire o_overcurrent_flag
);
  wire [2:0] hi = {o_c_high_gate, o_b_high_gate, o_a_high_gate};
  wire [2:0] lo = {o_c_low_gate, o_b_low_gate, o_a_low_gate};
  wire [2:0] flags = {o_phase_c_half_flag, o_phase_b_half_flag, o_phase_a_half_flag};
  wire live = i_reset_n && i_vdd_ok;
  reg [3:0] cs_hi_q;
  // cycles since chip select went high, saturating
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_hi_q <= 4'h0;
    end else if (!i_cs_n) begin
      cs_hi_q <= 4'h0;
    end else if (cs_hi_q != 4'hF) begin
      cs_hi_q <= cs_hi_q + 4'h1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_pin_fall;
    $fell(i_reset_n);
  endsequence
  sequence s_pin_quiet;
    o_gate_pulldown && !o_bias_en && hi == 3'h0 && lo == 3'h0;
  endsequence
  chk_gate_enable: assert property (
    (|{hi, lo}) |-> i_enable_first && i_enable_second)
    else $error("gate on while an enable is low");
  chk_no_overlap: assert property ((hi & lo) == 3'h0)
    else $error("both gates of one phase on");
  chk_pin_gates: assert property (!i_reset_n |-> hi == 3'h0 && lo == 3'h0)
    else $error("gate on while reset pin low");
  chk_pin_fast: assert property (s_pin_fall |-> ##[1:3] s_pin_quiet)
    else $error("reset pin not obeyed in time");
  chk_reg_off: assert property (s_pin_fall |-> ##[1:3] !o_vdd_reg_en)
    else $error("regulator still on after reset pin");
  chk_por_float: assert property (
    (!i_vdd_ok) [*5] |-> o_drv_oe_n && o_sdo_oe_n)
    else $error("drivers or serial out active below threshold");
  chk_sdo_float: assert property (i_cs_n [*5] |-> o_sdo_oe_n)
    else $error("serial out driven without chip select");
  chk_flag_follow: assert property (
    (live && $stable(i_phase_above_half)) [*6] |-> flags == i_phase_above_half)
    else $error("phase flags disagree with comparators");
  chk_oc_follow: assert property (
    $stable(i_overcurrent) [*4] |-> o_overcurrent_flag == i_overcurrent)
    else $error("overcurrent flag disagrees");
  chk_int_hold: assert property (
    disable iff (!i_rst_n || !live) $fell(o_int) |-> cs_hi_q >= 4'h2 && cs_hi_q <= 4'h7)
    else $error("interrupt dropped without a frame");
endmodule
bind pdrv_top pdrv_checker pdrv_checker_inst (.*);

// ==== tb/pdrv_host.sv ====
// host model driving serial frames into the pre-driver
`timescale 1ns/100ps
module pdrv_host (
  // clock and serial return
  input wire i_clk,
  input wire i_sdo,
  input wire i_sdo_oe_n,
  // serial pins towards the device
  output reg o_cs_n,
  output reg o_sclk,
  output reg o_sdi
);
  reg b;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    b = 1'b0;
  end
  // 160 ns serial clock, 100 ns lead and lag, 200 ns gap
  task frame(input [15:0] w, output [15:0] r);
    integer i;
    begin
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      repeat (5) @(posedge i_clk);
      for (i = 15; i >= 0; i = i - 1) begin
        o_sclk <= 1'b1;
        o_sdi <= w[i];
        repeat (4) @(posedge i_clk);
        b = i_sdo_oe_n ? ~b : i_sdo;
        r[i] = b;
        o_sclk <= 1'b0;
        repeat (4) @(posedge i_clk);
      end
      repeat (1) @(posedge i_clk);
      o_cs_n <= 1'b1;
      o_sdi <= 1'b0;
      repeat (10) @(posedge i_clk);
    end
  endtask
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the pre-driver control logic
`timescale 1ns/100ps
`include "pdrv_consts.vh"
module tb_top;
  reg i_clk = 1'b0;
  reg i_rst_n = 1'b0;
  reg i_reset_n = 1'b1;
  reg i_vdd_ok = 1'b1;
  reg i_enable_first = 1'b1;
  reg i_enable_second = 1'b1;
  reg [2:0] hi_n = 3'h7;
  reg [2:0] lo = 3'h0;
  reg [2:0] i_phase_above_half = 3'h0;
  reg i_overcurrent = 1'b0;
  reg [15:0] i_fault = 16'h0000;
  wire i_cs_n, i_sclk, i_sdi, o_sdo, o_sdo_oe_n, o_drv_oe_n, o_gate_pulldown;
  wire o_bias_en, o_vdd_reg_en, o_int, o_overcurrent_flag;
  wire o_phase_a_half_flag, o_phase_b_half_flag, o_phase_c_half_flag;
  wire [2:0] g_hi;
  wire [2:0] g_lo;
  integer err_total = 0;
  integer samples_checked = 0;
  integer p;
  reg [15:0] rd;
  always #10 i_clk = ~i_clk;
  pdrv_top pdrv_top_inst (
    .*,
    .i_a_high_cmd_n(hi_n[0]), .i_b_high_cmd_n(hi_n[1]), .i_c_high_cmd_n(hi_n[2]),
    .i_a_low_cmd(lo[0]), .i_b_low_cmd(lo[1]), .i_c_low_cmd(lo[2]),
    .o_a_high_gate(g_hi[0]), .o_b_high_gate(g_hi[1]), .o_c_high_gate(g_hi[2]),
    .o_a_low_gate(g_lo[0]), .o_b_low_gate(g_lo[1]), .o_c_low_gate(g_lo[2])
  );
  pdrv_host pdrv_host_inst (
    .i_clk(i_clk), .i_sdo(o_sdo), .i_sdo_oe_n(o_sdo_oe_n),
    .o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_sdi(i_sdi)
  );
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task stop_test;
    begin
      if (err_total == 0 && samples_checked > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge i_clk);
    end
  endtask
  task look(input integer n);
    begin
      cyc(n);
      @(negedge i_clk);
    end
  endtask
  task pulse(input [15:0] f);
    begin
      cyc(1);
      i_fault <= f;
      cyc(2);
      i_fault <= 16'h0000;
      look(6);
    end
  endtask
  task t_gates;
    begin
      for (p = 0; p < 3; p = p + 1) begin
        cyc(1);
        hi_n[p] <= 1'b0;
        look(8);
        chk(g_hi[p], 1'b0);
        cyc(1);
        hi_n[p] <= 1'b1;
        lo[p] <= 1'b1;
        look(4);
        chk(g_lo[p], 1'b1);
        cyc(1);
        lo[p] <= 1'b0;
        hi_n[p] <= 1'b0;
        look(8);
        chk({g_hi[p], g_lo[p]}, 2'h0);
        look(10);
        chk({g_hi[p], g_lo[p]}, 2'h2);
        cyc(1);
        lo[p] <= 1'b1;
        look(6);
        chk({g_hi[p], g_lo[p]}, 2'h0);
        cyc(1);
        hi_n[p] <= 1'b1;
        lo[p] <= 1'b0;
      end
      cyc(20);
      lo[0] <= 1'b1;
      look(20);
      chk(g_lo[0], 1'b1);
      cyc(1);
      i_enable_second <= 1'b0;
      #1;
      chk(g_lo[0], 1'b0);
      look(5);
      chk(g_lo[0], 1'b0);
      cyc(1);
      i_enable_second <= 1'b1;
      lo[0] <= 1'b0;
      cyc(4);
      hi_n[0] <= 1'b0;
      look(20);
      chk(g_hi[0], 1'b0);
      cyc(1);
      hi_n[0] <= 1'b1;
    end
  endtask
  task t_ovr;
    begin
      pdrv_host_inst.frame({`PDRV_OP_CONFIG, 4'h0, 8'h02}, rd);
      cyc(1);
      lo[1] <= 1'b1;
      look(4);
      chk(g_lo[1], 1'b1);
      cyc(1);
      hi_n[1] <= 1'b0;
      look(6);
      chk({g_hi[1], g_lo[1]}, 2'h1);
      cyc(1);
      lo[1] <= 1'b0;
      hi_n[1] <= 1'b1;
      look(20);
      pdrv_host_inst.frame({`PDRV_OP_CONFIG, 4'h0, 8'h01}, rd);
      cyc(1);
      lo[1] <= 1'b1;
      look(4);
      chk(g_lo[1], 1'b1);
      cyc(1);
      lo[1] <= 1'b0;
      hi_n[1] <= 1'b0;
      look(4);
      chk({g_hi[1], g_lo[1]}, 2'h2);
      cyc(1);
      hi_n[1] <= 1'b1;
      pdrv_host_inst.frame({`PDRV_OP_CONFIG, 4'h0, 8'h00}, rd);
    end
  endtask
  task t_reset;
    begin
      cyc(1);
      i_reset_n <= 1'b0;
      look(3);
      chk({o_bias_en, o_vdd_reg_en, o_gate_pulldown}, 3'h1);
      cyc(1);
      i_reset_n <= 1'b1;
      look(5);
      chk({o_bias_en, o_vdd_reg_en, o_gate_pulldown}, 3'h6);
      cyc(5);
    end
  endtask
  task t_por;
    begin
      cyc(1);
      i_vdd_ok <= 1'b0;
      look(5);
      chk(o_drv_oe_n, 1'b1);
      pdrv_host_inst.frame({`PDRV_OP_MASK_LO, 4'h0, 8'hFF}, rd);
      cyc(1);
      i_vdd_ok <= 1'b1;
      look(5);
      chk(o_drv_oe_n, 1'b0);
      cyc(5);
    end
  endtask
  task t_int;
    begin
      pulse(16'h0008);
      chk(o_int, 1'b1);
      pdrv_host_inst.frame({`PDRV_OP_NOP, 12'h000}, rd);
      chk(rd, 16'h0008);
      look(1);
      chk(o_int, 1'b1);
      pdrv_host_inst.frame({`PDRV_OP_CLR_INT, 12'h000}, rd);
      look(1);
      chk(o_int, 1'b0);
      pdrv_host_inst.frame({`PDRV_OP_MASK_LO, 4'h0, 8'h08}, rd);
      pdrv_host_inst.frame({`PDRV_OP_MASK_HI, 4'h0, 8'h02}, rd);
      pdrv_host_inst.frame({`PDRV_OP_DEADTIME, 4'h0, `PDRV_DT_RST}, rd);
      pdrv_host_inst.frame({`PDRV_OP_CONFIG, 4'h0, 8'h00}, rd);
      pulse(16'h0208);
      chk(o_int, 1'b0);
      pulse(16'h0010);
      chk(o_int, 1'b1);
    end
  endtask
  task t_flags(input [2:0] ph, input oc);
    begin
      cyc(1);
      i_phase_above_half <= ph;
      i_overcurrent <= oc;
      look(6);
      chk({o_phase_c_half_flag, o_phase_b_half_flag, o_phase_a_half_flag}, ph);
      chk(o_overcurrent_flag, oc);
    end
  endtask
  initial begin
    cyc(16);
    i_rst_n <= 1'b1;
    cyc(8);
    t_gates;
    t_reset;
    t_por;
    t_int;
    t_ovr;
    t_flags(3'h5, 1'b1);
    t_flags(3'h2, 1'b0);
    stop_test;
  end
  initial begin
    #1500000;
    err_total = err_total + 1;
    stop_test;
  end
endmodule
